// >>> rtl/vector_place.v
/*
 Reset and interrupt vector placement: issues the program counter load on
 reset and on each accepted interrupt, with relocatable vector table and
 timed vector-select change over an AHB-Lite register slave.
 Assumes the core takes PC_LOAD as a one-cycle load and that each source
 drops its request after IRQ_ACK. All inputs synchronous to CLK.
*/
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`include "vector_place_defines.vh"
module vector_place #(
	parameter AW = 12,
	parameter NSRC = 18,
	parameter IW = 5
)
(
	input wire CLK,
	input wire RST,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output reg HREADYOUT,
	output reg HRESP,
	input wire BOOT_RESET_FUSE,
	input wire [AW-1:0] BOOT_START,
	input wire [3:0] RESET_CAUSE,
	input wire [NSRC-1:0] IRQ_REQ,
	input wire GLOBAL_IE,
	input wire CORE_READY,
	output reg PC_LOAD,
	output reg [AW-1:0] PC_ADDR,
	output reg [NSRC-1:0] IRQ_ACK,
	output reg IRQ_BLOCKED
);
	localparam [1:0] S_CAPTURE = 2'b00;
	localparam [1:0] S_RESET_LOAD = 2'b01;
	localparam [1:0] S_RUN = 2'b10;
	localparam [1:0] S_SETTLE = 2'b11;

	reg [1:0] state;
	reg [1:0] next_state;
	reg fuse;
	reg vector_select_bit;
	reg vector_change_enable;
	reg [2:0] vce_count;
	reg [2:0] hold_count;
	reg [IW-1:0] last_vector;
	reg wr_pending;
	reg [7:0] wr_addr;

	wire any_req;
	wire [NSRC-1:0] grant;
	wire [IW-1:0] pick_index;
	wire addr_phase;
	wire ctrl_write;
	wire wr_vce;
	wire wr_vsel;
	wire any_cause;
	wire blocked;
	wire take_irq;
	wire wr_hit;
	wire [AW-1:0] reset_addr;
	wire [AW-1:0] vector_base;
	wire [AW-1:0] irq_target;
	reg [AW-1:0] offset;
	reg [31:0] read_value;

	vector_pick #(
		.N(NSRC),
		.IW(IW)
	) picker (
		.req(IRQ_REQ),
		.any(any_req),
		.grant(grant),
		.index(pick_index)
	);

	// Fuse alone chooses reset target, vector select alone the table
	assign reset_addr = (fuse == `FUSE_PROGRAMMED) ? BOOT_START : `RESET_WORD; // see (R10) (R9)
	assign vector_base = vector_select_bit ? (BOOT_START + `TABLE_BASE) : `TABLE_BASE; // see (R8)
	// Offset minus one keeps request zero on the first table word
	assign irq_target = vector_base + offset - `TABLE_BASE; // see (R12)

	// Fixed slot for each source; priority of lowest index is our choice
	always @*
	begin
		case (pick_index)
			5'h00: offset = `OFS_EXT0; // see (R2)
			5'h01: offset = `OFS_EXT1; // see (R2)
			5'h02: offset = `OFS_T2_CMP; // see (R3)
			5'h03: offset = `OFS_T2_OVF; // see (R3)
			5'h04: offset = `OFS_T1_CAP; // see (R3)
			5'h05: offset = `OFS_T1_CMPA; // see (R4)
			5'h06: offset = `OFS_T1_CMPB; // see (R4)
			5'h07: offset = `OFS_T1_OVF; // see (R4)
			5'h08: offset = `OFS_T0_OVF; // see (R4)
			5'h09: offset = `OFS_SYNC_SER; // see (R5)
			5'h0A: offset = `OFS_UART_RX; // see (R5)
			5'h0B: offset = `OFS_UART_EMPTY; // see (R5)
			5'h0C: offset = `OFS_UART_TX; // see (R5)
			5'h0D: offset = `OFS_CONVERTER; // see (R6)
			5'h0E: offset = `OFS_NV_READY; // see (R6)
			5'h0F: offset = `OFS_COMPARATOR; // see (R6)
			5'h10: offset = `OFS_TWO_WIRE; // see (R6)
			5'h11: offset = `OFS_STORE_READY; // see (R6)
			default: offset = `OFS_EXT0;
		endcase
	end

	// Bus address phase and control-register write effects
	assign addr_phase = HSEL & HREADY & HTRANS[`HTRANS_NONSEQ_BIT];
	// Writes outside the register window are dropped, as reads give zero
	assign wr_hit = addr_phase & HWRITE & (HADDR[31:8] == 24'h000000);
	assign ctrl_write = wr_pending & (wr_addr == `REG_CONTROL);
	assign wr_vce = ctrl_write & HWDATA[`CTRL_VCE_BIT];
	// Select only changes while change-enable is open and the write clears it
	assign wr_vsel = ctrl_write & ~HWDATA[`CTRL_VCE_BIT] & vector_change_enable; // see (R13)

	assign any_cause = |RESET_CAUSE;
	// Blocking leaves the global flag alone; it only gates acceptance
	// The cycle that sets change-enable is blocked too, not only those after
	assign blocked = wr_vce | vector_change_enable | (hold_count != 3'h0); // see (R14)
	assign take_irq = (state == S_RUN) & any_req & GLOBAL_IE & CORE_READY & ~blocked;

	always @*
	begin
		case (state)
			S_CAPTURE: next_state = S_RESET_LOAD;
			// Settle after the reset load too, so two loads never abut
			S_RESET_LOAD: next_state = S_SETTLE;
			S_RUN: next_state = take_irq ? S_SETTLE : S_RUN;
			S_SETTLE: next_state = S_RUN;
			default: next_state = S_CAPTURE;
		endcase
		if (any_cause)
			next_state = S_CAPTURE;
	end

	always @(posedge CLK or posedge RST)
	begin
		if (RST)
			state <= S_CAPTURE;
		else
			state <= next_state;
	end

	// Fuse is sampled after reset release, never under the async reset
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
			fuse <= 1'b1;
		else if (state == S_CAPTURE)
			fuse <= BOOT_RESET_FUSE; // see (R7)
	end

	// Change-enable window and post-select hold
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			vector_select_bit <= 1'b0;
			vector_change_enable <= 1'b0;
			vce_count <= 3'h0;
			hold_count <= 3'h0;
		end
		else if (any_cause)
		begin
			vector_select_bit <= 1'b0;
			vector_change_enable <= 1'b0;
			vce_count <= 3'h0;
			hold_count <= 3'h0;
		end
		else if (wr_vce)
		begin
			vector_change_enable <= 1'b1; // see (R13)
			vce_count <= `VCE_CYCLES;
			hold_count <= 3'h0;
		end
		else if (wr_vsel)
		begin
			vector_select_bit <= HWDATA[`CTRL_VSEL_BIT]; // see (R8)
			vector_change_enable <= 1'b0; // see (R13)
			vce_count <= 3'h0;
			hold_count <= `SEL_HOLD_CYCLES; // see (R14)
		end
		else
		begin
			if (vce_count == 3'h1)
				vector_change_enable <= 1'b0; // see (R13)
			if (vce_count != 3'h0)
				vce_count <= vce_count - 3'h1;
			if (hold_count != 3'h0)
				hold_count <= hold_count - 3'h1;
		end
	end

	// Program counter loads: reset target or vector slot
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			PC_LOAD <= 1'b0;
			PC_ADDR <= `RESET_WORD;
			IRQ_ACK <= {NSRC{1'b0}};
			last_vector <= {IW{1'b0}};
		end
		else
		begin
			PC_LOAD <= 1'b0;
			IRQ_ACK <= {NSRC{1'b0}};
			if (state == S_RESET_LOAD && !any_cause)
			begin
				PC_LOAD <= 1'b1;
				PC_ADDR <= reset_addr; // see (R1) (R7) (R12)
			end
			else if (take_irq && !any_cause)
			begin
				PC_LOAD <= 1'b1;
				// Vector word is only a jump target, never accessed specially
				PC_ADDR <= irq_target; // see (R12) (R11)
				IRQ_ACK <= grant;
				last_vector <= pick_index;
			end
		end
	end

	// Status pin lags the internal block by one cycle
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
			IRQ_BLOCKED <= 1'b0;
		else
			IRQ_BLOCKED <= blocked; // see (R14)
	end

	// Write address held for the data phase, when HWDATA arrives
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pending <= wr_hit;
			wr_addr <= HADDR[7:0];
		end
	end

	// Bus slave: zero wait states, always OKAY
	// No register needs more than one cycle, so there is no stall logic
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			HREADYOUT <= 1'b1;
			HRESP <= `HRESP_OKAY;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP <= `HRESP_OKAY;
		end
	end

	always @*
	begin
		read_value = 32'h00000000;
		if (HADDR[31:8] == 24'h000000)
		begin
			case (HADDR[7:0])
				`REG_CONTROL:
				begin
					read_value[`CTRL_VSEL_BIT] = vector_select_bit;
					read_value[`CTRL_VCE_BIT] = vector_change_enable;
				end
				`REG_STATUS:
				begin
					read_value[`STAT_FUSE_BIT] = fuse;
					read_value[`STAT_BLOCKED_BIT] = blocked;
					read_value[`STAT_VCE_BIT] = vector_change_enable;
					read_value[`STAT_VSEL_BIT] = vector_select_bit;
				end
				`REG_RESET_ADDR: read_value[AW-1:0] = reset_addr;
				`REG_VECTOR_BASE: read_value[AW-1:0] = vector_base;
				`REG_LAST_VECTOR: read_value[IW-1:0] = last_vector;
				default: read_value = 32'h00000000;
			endcase
		end
	end

	// Read data registered at the address phase so it stands in the data phase
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
			HRDATA <= 32'h00000000;
		else if (addr_phase && !HWRITE)
			HRDATA <= read_value;
	end
endmodule

// >>> rtl/vector_place_defines.vh
/*
 Constants for the reset and interrupt vector placement block: vector
 offsets, register map, control fields and timing counts.
 Assumes a word-addressed program memory and a 32-bit AHB-Lite register bus.
*/
// Summary of operation
// (R1) Every reset cause jumps to word 0x000 while the boot-reset fuse is unprogrammed.
// (R2) External request zero uses offset 0x001, request one uses 0x002.
// (R3) Timer two compare 0x003, overflow 0x004; timer one capture 0x005.
// (R4) Timer one compare A 0x006, compare B 0x007, overflow 0x008; timer zero overflow 0x009.
// (R5) Sync serial 0x00A, uart receive 0x00B, tx empty 0x00C, transmit done 0x00D.
// (R6) Converter 0x00E, nv data 0x00F, comparator 0x010, two-wire 0x011, store 0x012.
// (R7) Programmed boot-reset fuse starts execution at the boot reset address after reset.
// (R8) Vector select one adds table offset to boot start; zero puts table at 0x001.
// (R9) Fuse picks reset address, vector select picks vector base, all four combinations.
// (R10) Fuse value 1 means unprogrammed (reset at zero), 0 means programmed.
// (R11) Vector words are plain program memory; unused ones may hold code.
// (R12) Accepted interrupt loads vector base plus offset minus one; reset loads reset address.
// (R13) Set change-enable, then write vector select within four cycles; hardware clears enable.
// (R14) Block interrupts from change-enable until after following instruction, or four cycles.
`ifndef VECTOR_PLACE_DEFINES_VH
`define VECTOR_PLACE_DEFINES_VH

`define RESET_WORD 12'h000
`define TABLE_BASE 12'h001
`define OFS_EXT0 12'h001
`define OFS_EXT1 12'h002
`define OFS_T2_CMP 12'h003
`define OFS_T2_OVF 12'h004
`define OFS_T1_CAP 12'h005
`define OFS_T1_CMPA 12'h006
`define OFS_T1_CMPB 12'h007
`define OFS_T1_OVF 12'h008
`define OFS_T0_OVF 12'h009
`define OFS_SYNC_SER 12'h00A
`define OFS_UART_RX 12'h00B
`define OFS_UART_EMPTY 12'h00C
`define OFS_UART_TX 12'h00D
`define OFS_CONVERTER 12'h00E
`define OFS_NV_READY 12'h00F
`define OFS_COMPARATOR 12'h010
`define OFS_TWO_WIRE 12'h011
`define OFS_STORE_READY 12'h012

`define FUSE_PROGRAMMED 1'b0

`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_RESET_ADDR 8'h08
`define REG_VECTOR_BASE 8'h0C
`define REG_LAST_VECTOR 8'h10

`define CTRL_VCE_BIT 0
`define CTRL_VSEL_BIT 1
`define STAT_FUSE_BIT 0
`define STAT_BLOCKED_BIT 1
`define STAT_VCE_BIT 2
`define STAT_VSEL_BIT 3

`define VCE_CYCLES 3'h4
`define SEL_HOLD_CYCLES 3'h2

`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// >>> rtl/vector_pick.v
/*
 Lowest-index request picker: one-hot grant and binary index of the
 lowest set request bit.
 Assumes requests are already gated by their source enables.
*/
`timescale 1ns/1ns
module vector_pick #(
	parameter N = 18,
	parameter IW = 5
)
(
	input wire [N-1:0] req,
	output wire any,
	output wire [N-1:0] grant,
	output wire [IW-1:0] index
);
	wire [N:0] seen;
	wire [IW-1:0] acc [0:N];

	assign seen[0] = 1'b0;
	assign acc[0] = {IW{1'b0}};

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : slot
			localparam [IW-1:0] VAL = i;
			assign grant[i] = req[i] & ~seen[i];
			assign seen[i + 1] = seen[i] | req[i];
			assign acc[i + 1] = acc[i] | (grant[i] ? VAL : {IW{1'b0}});
		end
	endgenerate

	assign any = seen[N];
	assign index = acc[N];
endmodule

// >>> testbench/vector_place_asserts.sv
/*
 Port checker for the vector placement block.
 Assumes it is bound to vector_place and sees only its ports; one clock.
*/
`timescale 1ns/1ns
module vector_place_asserts #(
	parameter AW = 12,
	parameter NSRC = 18
)
(
	input wire CLK,
	input wire RST,
	input wire HREADYOUT,
	input wire HRESP,
	input wire BOOT_RESET_FUSE,
	input wire [AW-1:0] BOOT_START,
	input wire GLOBAL_IE,
	input wire CORE_READY,
	input wire [NSRC-1:0] IRQ_REQ,
	input wire PC_LOAD,
	input wire [AW-1:0] PC_ADDR,
	input wire [NSRC-1:0] IRQ_ACK,
	input wire IRQ_BLOCKED
);
default clocking @(posedge CLK); endclocking
default disable iff (RST);
a_bus_okay: assert property (HREADYOUT && !HRESP)
	else $error("bus not ready or not okay");
a_reset_target: assert property ($fell(RST) |-> ##2 PC_LOAD &&
	PC_ADDR == ($past(BOOT_RESET_FUSE, 2) ? {AW{1'b0}} : $past(BOOT_START)))
	else $error("wrong reset target");
a_ack_lowest: assert property (IRQ_ACK != 0 |->
	IRQ_ACK == ($past(IRQ_REQ) & (~$past(IRQ_REQ) + 1'b1)))
	else $error("ack is not the lowest request");
a_ack_gated: assert property (IRQ_ACK != 0 |->
	PC_LOAD && $past(GLOBAL_IE) && $past(CORE_READY))
	else $error("ack without load or permission");
a_ack_onehot: assert property ($onehot0(IRQ_ACK))
	else $error("ack not one-hot");
a_load_pulse: assert property (PC_LOAD |=> !PC_LOAD)
	else $error("load longer than one cycle");
a_take_spacing: assert property (IRQ_ACK != 0 |=> IRQ_ACK == 0)
	else $error("takes too close");
a_block_bound: assert property ($rose(IRQ_BLOCKED) |-> ##[1:8] !IRQ_BLOCKED)
	else $error("block not released");
endmodule
bind vector_place vector_place_asserts #(.AW(AW), .NSRC(NSRC)) chk (.CLK(CLK), .RST(RST),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .BOOT_RESET_FUSE(BOOT_RESET_FUSE),
	.BOOT_START(BOOT_START), .GLOBAL_IE(GLOBAL_IE), .CORE_READY(CORE_READY),
	.IRQ_REQ(IRQ_REQ), .PC_LOAD(PC_LOAD), .PC_ADDR(PC_ADDR), .IRQ_ACK(IRQ_ACK),
	.IRQ_BLOCKED(IRQ_BLOCKED));

// >>> testbench/irq_sources.sv
/*
 Interrupt source model: level requests raised by the bench.
 Assumes a one-hot acknowledge pulse per taken request.
*/
`timescale 1ns/1ns
module irq_sources
(
	input wire clk,
	input wire rst,
	input wire [17:0] raise,
	input wire [17:0] ack,
	output reg [17:0] req
);
always @(posedge clk or posedge rst)
begin
	if (rst)
		req <= 18'h00000;
	else
		req <= (req | raise) & ~ack; // Held until taken; a raise in the cycle of its own ack is cleared too
end
endmodule

// >>> testbench/vector_place_tb.sv
/*
 Testbench for vector placement: reset targets, table, relocation, change window.
 Assumes the AHB slave answers with zero wait and sources drop after ack.
*/
`timescale 1ns/1ns
module vector_place_tb;
reg clk = 0, rst = 1, hsel = 0, hwrite = 0, fuse = 1, rdy = 1, gie = 1;
reg [31:0] haddr = 0, hwdata = 0, r;
reg [1:0] htrans = 0;
reg [3:0] cause = 0;
reg [11:0] boot_start = 12'hC00;
reg [17:0] raise = 0;
wire [31:0] hrdata;
wire hreadyout, hresp, pc_load, blocked;
wire [11:0] pc_addr;
wire [17:0] req, ack;
integer n_mismatch = 0, check_count = 0, cyc = 0, waited, k, j;
always #4 clk = ~clk;
vector_place DUT (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
	.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
	.HREADYOUT(hreadyout), .HRESP(hresp), .BOOT_RESET_FUSE(fuse), .BOOT_START(boot_start),
	.RESET_CAUSE(cause), .IRQ_REQ(req), .GLOBAL_IE(gie), .CORE_READY(rdy),
	.PC_LOAD(pc_load), .PC_ADDR(pc_addr), .IRQ_ACK(ack), .IRQ_BLOCKED(blocked));
irq_sources src (.clk(clk), .rst(rst), .raise(raise), .ack(ack), .req(req));
task report_and_stop;
begin
	$display("mismatches %0d checks %0d", n_mismatch, check_count);
	if (n_mismatch == 0 && check_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
end
endtask
always @(posedge clk)
begin
	cyc <= cyc + 1;
	rdy <= ($urandom % 4) != 0; // Core busy one cycle in four, stretches takes
	if (cyc == 6000)
	begin
		n_mismatch = n_mismatch + 1;
		report_and_stop;
	end
end
task check(input [31:0] got, input [31:0] exp);
begin
	check_count = check_count + 1;
	if (got !== exp)
	begin
		n_mismatch = n_mismatch + 1;
		$display("[ERR] %0t got %h expected %h", $time, got, exp);
	end
end
endtask
task bus(input w, input [31:0] a, input [31:0] d);
begin
	haddr <= a; hwrite <= w; htrans <= 2'h2; hsel <= 1'b1;
	@(posedge clk);
	while (hreadyout !== 1'b1) @(posedge clk);
	htrans <= 2'h0; hwdata <= d;
	@(posedge clk);
	while (hreadyout !== 1'b1) @(posedge clk);
	r = hrdata;
end
endtask
task wait_load;
begin
	waited = 0;
	while (pc_load !== 1'b1 && waited < 40)
	begin
		@(posedge clk);
		waited = waited + 1;
	end
end
endtask
function [11:0] vec(input sel, input integer n);
	vec = (sel ? boot_start + 12'h001 : 12'h001) + n[11:0];
endfunction
task expect_take(input integer n, input sel);
begin
	wait_load;
	check({pc_load, pc_addr}, {1'b1, vec(sel, n)});
	check(ack, 32'h1 << n);
	@(posedge clk);
end
endtask
task take(input integer n, input sel);
begin
	raise <= 18'h00001 << n;
	@(posedge clk);
	raise <= 18'h00000;
	expect_take(n, sel);
	@(posedge clk);
end
endtask
task do_reset(input f, input integer n);
begin
	fuse <= f; rst <= 1'b1;
	repeat (n) @(posedge clk);
	rst <= 1'b0;
	wait_load;
	check(pc_addr, f ? 32'h0 : boot_start);
	@(posedge clk);
end
endtask
task relocate;
begin
	bus(1, 32'h0, 32'h1);
	bus(1, 32'h0, 32'h2);
	check(blocked, 1'b1);
	bus(0, 32'h4, 32'h0);
	check(r[3:1], 3'b101);
	repeat (2) @(posedge clk);
	check(blocked, 1'b0);
end
endtask
initial
begin
	void'($urandom(32'h4f0d8402));
	@(posedge clk);
	boot_start <= 12'h800 | 12'($urandom % 1024);
	do_reset(1, 11);
	for (k = 0; k < 18; k = k + 1)
		take(k, 0);
	// Several waiting at once, held off by the global flag, then lowest first
	gie <= 1'b0;
	raise <= 18'h2A000;
	@(posedge clk);
	raise <= 18'h00000;
	wait_load;
	check(waited, 40);
	gie <= 1'b1;
	for (k = 13; k < 18; k = k + 2)
		expect_take(k, 0);
	bus(0, 32'h8, 32'h0);
	check(r, 32'h0);
	bus(0, 32'h40, 32'h0);
	check(r, 32'h0);
	bus(1, 32'h0, 32'h1);
	take(7, 0);
	check(waited >= 4, 1);
	bus(1, 32'h0, 32'h2);
	bus(0, 32'h4, 32'h0);
	check(r[3:1], 3'b000);
	relocate;
	for (j = 0; j < 20; j = j + 1)
		take($urandom % 18, 1);
	do_reset(0, 2);
	take(17, 0);
	relocate;
	take($urandom % 18, 1);
	cause <= 4'h1 << ($urandom % 4);
	@(posedge clk);
	cause <= 4'h0;
	wait_load;
	check(pc_addr, boot_start);
	@(posedge clk);
	take(0, 0);
	report_and_stop;
end
endmodule
